// ==== src/pkt_seq_pkg.sv ====
// Shared constants and a helper function for the paging packet sequencer pair
package pkt_seq_pkg;
  // Packet type codes carried in the top nibble of a packet word
  localparam logic [3:0] PKT_NONE   = 4'h0;
  localparam logic [3:0] PKT_ADDR   = 4'h1;
  localparam logic [3:0] PKT_LADDR  = 4'h2;
  localparam logic [3:0] PKT_VECTOR = 4'h3;
  localparam logic [3:0] PKT_MSG    = 4'h4;
  localparam logic [3:0] PKT_BIW    = 4'h5;
  localparam logic [3:0] PKT_STATUS = 4'h6;
  localparam logic [3:0] PKT_AFM    = 4'h7;

  // Received word kinds presented by the demodulator side
  localparam logic [2:0] WK_BIW     = 3'h0;
  localparam logic [2:0] WK_ADDR    = 3'h1;
  localparam logic [2:0] WK_LADDR   = 3'h2;
  localparam logic [2:0] WK_VECTOR  = 3'h3;
  localparam logic [2:0] WK_MSG     = 3'h4;
  localparam logic [2:0] WK_IDLE    = 3'h7;

  // Fragmentable vector type codes
  localparam logic [2:0] VT_SECURE  = 3'h0;
  localparam logic [2:0] VT_ALPHA   = 3'h5;
  localparam logic [2:0] VT_HEXBIN  = 3'h6;

  // Packet word layout: [31:28] type, [27:26] phase, [25:21] position
  localparam int PKT_TYPE_LSB  = 28;
  localparam int PKT_PHASE_LSB = 26;
  localparam int PKT_POS_LSB   = 21;
  // Vector packet: [20:16] first, [15:11] last message position
  localparam int PKT_FIRST_LSB = 16;
  localparam int PKT_LAST_LSB  = 11;
  // Status packet end-of-frame flag
  localparam int PKT_EOF_BIT   = 0;
  // Host-to-device all-frame-mode packet decrement bit
  localparam int PKT_DEC_BIT   = 0;
  // Message packet continued flag
  localparam int PKT_CONT_BIT  = 20;

  // Rate select codes; the device decides the phases carried per rate
  localparam logic [1:0] RATE_1600 = 2'h0;
  localparam logic [1:0] RATE_3200 = 2'h1;
  localparam logic [1:0] RATE_6400 = 2'h2;

  localparam logic [7:0] AF_CNT_RESET = 8'h00;

  function automatic logic is_frag_type(input logic [2:0] vt);
    return (vt == VT_SECURE) || (vt == VT_ALPHA) || (vt == VT_HEXBIN);
  endfunction
endpackage

// ==== src/pkt_seq_if.sv ====
// Packet link between the sequencer and the host controller
`timescale 1ns/1ps
`default_nettype none
interface pkt_seq_if;
  logic [31:0] d2h_data;
  logic        d2h_valid;
  logic        d2h_ready;
  logic [31:0] h2d_data;
  logic        h2d_valid;
  logic        h2d_ready;

  modport device (output d2h_data, output d2h_valid, input d2h_ready,
                  input h2d_data, input h2d_valid, output h2d_ready);
  modport host   (input d2h_data, input d2h_valid, output d2h_ready,
                  output h2d_data, output h2d_valid, input h2d_ready);
endinterface
`default_nettype wire

// ==== src/pkt_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pkt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_RST_B,
  // Fill side
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  // Drain side
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be 2**n >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             push;
  logic             pop;

  assign o_valid = (wptr != rptr);
  assign o_ready = (wptr[AW-1:0] != rptr[AW-1:0]) || (wptr[AW] == rptr[AW]);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge I_CLK) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop)  rptr <= rptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== src/pkt_seq_device.sv ====
// Decoder-side packet sequencer with all-frame-mode counter
`timescale 1ns/1ps
`default_nettype none
module pkt_seq_device #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // Received word stream, one word per cycle while valid
  input  wire logic        I_WORD_VALID,
  output logic             O_WORD_READY,
  input  wire logic [2:0]  I_WORD_KIND,
  input  wire logic [1:0]  I_PHASE,
  input  wire logic [4:0]  I_WORD_POSITION,
  input  wire logic [20:0] I_WORD_DATA,
  input  wire logic        I_FRAME_END,
  // Configuration and status
  input  wire logic [1:0]  I_RATE,
  input  wire logic        I_BIW_FWD_EN,
  input  wire logic        I_FORCED_ALL_FRAME_BIT,
  input  wire logic        I_TEMP_ADDR_PENDING,
  output logic             O_ALL_FRAME,
  output logic [7:0]       O_AF_COUNT,
  // Packet link
  pkt_seq_if.device        link
);
  // Incoming word data layout, per kind:
  //  address:   [4:0] vector position
  //  vector:    [2:0] vector_type_field, [7:3] first, [12:8] last
  //  message:   [20] continued flag, rest payload
  //  block info: payload
  // The demodulator presents words already ordered block by block and
  // phase by phase; phases the rate does not carry are dropped here.

  logic [31:0] pkt_data;
  logic        pkt_valid;
  logic        pkt_ready;
  logic [31:0] ans_data;
  logic        ans_pend;
  logic [31:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        phase_ok;
  logic        long_follow;
  logic [1:0]  long_phase;
  logic        eof_pend;
  logic        dec_req;

  function automatic logic [31:0] mk_pkt(input logic [3:0] t,
                                         input logic [1:0] ph,
                                         input logic [4:0] pos,
                                         input logic [20:0] body);
    mk_pkt = {t, ph, pos, body};
  endfunction

  // Highest rate four phases, two-phase two, lowest only phase A
  always_comb begin
    case (I_RATE)
      pkt_seq_pkg::RATE_6400: phase_ok = 1'b1;
      pkt_seq_pkg::RATE_3200: phase_ok = (I_PHASE[0] == 1'b0);
      default:                phase_ok = (I_PHASE == 2'h0);
    endcase
  end

  // Word in this cycle becomes at most one packet
  always_comb begin
    pkt_valid = 1'b0;
    pkt_data  = '0;
    if (eof_pend) begin
      pkt_valid = 1'b1;
      pkt_data  = mk_pkt(pkt_seq_pkg::PKT_STATUS, 2'h0, 5'h00,
                         21'h000001);
    end else if (I_WORD_VALID && phase_ok) begin
      case (I_WORD_KIND)
        pkt_seq_pkg::WK_BIW: begin
          // Position zero info word is consumed silently
          pkt_valid = (I_WORD_POSITION != 5'h00) && I_BIW_FWD_EN;
          pkt_data  = mk_pkt(pkt_seq_pkg::PKT_BIW, I_PHASE,
                             I_WORD_POSITION, I_WORD_DATA);
        end
        pkt_seq_pkg::WK_ADDR: begin
          pkt_valid = 1'b1;
          pkt_data  = mk_pkt(pkt_seq_pkg::PKT_ADDR, I_PHASE,
                             I_WORD_DATA[4:0], I_WORD_DATA);
        end
        pkt_seq_pkg::WK_LADDR: begin
          pkt_valid = 1'b1;
          pkt_data  = mk_pkt(pkt_seq_pkg::PKT_LADDR, I_PHASE,
                             I_WORD_DATA[4:0], I_WORD_DATA);
        end
        pkt_seq_pkg::WK_VECTOR: begin
          pkt_valid = 1'b1;
          pkt_data  = mk_pkt(pkt_seq_pkg::PKT_VECTOR, I_PHASE,
                             I_WORD_POSITION,
                             {I_WORD_DATA[7:3], I_WORD_DATA[12:8],
                              8'h00, I_WORD_DATA[2:0]});
        end
        pkt_seq_pkg::WK_MSG: begin
          pkt_valid = 1'b1;
          pkt_data  = mk_pkt(pkt_seq_pkg::PKT_MSG, I_PHASE,
                             I_WORD_POSITION, I_WORD_DATA);
        end
        default: pkt_valid = 1'b0;
      endcase
    end
  end

  // Stall the word stream whenever a packet cannot be queued
  assign O_WORD_READY = !eof_pend && (!pkt_valid || pkt_ready);

  // Frame-end status follows the last word of the frame
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      eof_pend <= 1'b0;
    end else if (eof_pend) begin
      eof_pend <= !pkt_ready;
    end else if (I_WORD_VALID && O_WORD_READY && I_FRAME_END) begin
      eof_pend <= 1'b1;
    end
  end

  // Track a long address until the vector word in its phase
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      long_follow <= 1'b0;
      long_phase  <= 2'h0;
    end else if (I_WORD_VALID && O_WORD_READY && phase_ok) begin
      if (I_WORD_KIND == pkt_seq_pkg::WK_LADDR) begin
        long_follow <= 1'b1;
        long_phase  <= I_PHASE;
      end else if (I_WORD_KIND == pkt_seq_pkg::WK_VECTOR &&
                   I_PHASE == long_phase) begin
        long_follow <= 1'b0;
      end
    end
  end

  pkt_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .I_CLK   (I_CLK),
    .I_RST_B (I_RST_B),
    .i_data  (pkt_data),
    .i_valid (pkt_valid),
    .o_ready (pkt_ready),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (fifo_ready)
  );

  // Host writes are answered by the next outbound packet slot
  assign link.h2d_ready = !ans_pend;
  assign dec_req = link.h2d_valid && !ans_pend &&
                   (link.h2d_data[31:28] == pkt_seq_pkg::PKT_AFM) &&
                   link.h2d_data[pkt_seq_pkg::PKT_DEC_BIT];

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ans_pend <= 1'b0;
      ans_data <= '0;
    end else if (link.h2d_valid && !ans_pend) begin
      ans_pend <= 1'b1;
      // A packet the host takes directly this cycle is not sent twice
      ans_data <= (fifo_valid && !link.d2h_ready) ? fifo_data :
                  mk_pkt(pkt_seq_pkg::PKT_NONE, 2'h0, 5'h00, 21'h0);
    end else if (ans_pend && link.d2h_ready) begin
      ans_pend <= 1'b0;
    end
  end

  // Answer consumes the queued packet it carries
  assign fifo_ready     = link.h2d_valid && !ans_pend ? 1'b1 :
                          (!ans_pend && link.d2h_ready);
  assign link.d2h_valid = ans_pend || fifo_valid;
  assign link.d2h_data  = ans_pend ? ans_data : fifo_data;

  // All-frame-mode counter
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_AF_COUNT <= pkt_seq_pkg::AF_CNT_RESET;
    end else begin
      logic inc;
      inc = I_WORD_VALID && O_WORD_READY && phase_ok &&
            I_WORD_KIND == pkt_seq_pkg::WK_VECTOR &&
            pkt_seq_pkg::is_frag_type(I_WORD_DATA[2:0]);
      if (inc && !dec_req) begin
        O_AF_COUNT <= O_AF_COUNT + 8'h01;
      end else if (dec_req && !inc && O_AF_COUNT != 8'h00) begin
        O_AF_COUNT <= O_AF_COUNT - 8'h01;
      end
    end
  end

  // Normal decoding only once nothing keeps all-frame alive
  assign O_ALL_FRAME = (O_AF_COUNT != 8'h00) || I_TEMP_ADDR_PENDING ||
                       I_FORCED_ALL_FRAME_BIT;
endmodule
`default_nettype wire

// ==== src/pkt_seq_host.sv ====
// Host end: gathers packets, issues all-frame decrements
`timescale 1ns/1ps
`default_nettype none
module pkt_seq_host (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // Received packets to host software
  output logic [31:0]      O_PKT_DATA,
  output logic             O_PKT_VALID,
  // Fragment bookkeeping
  output logic [7:0]       O_FRAG_PENDING,
  // Packet link
  pkt_seq_if.host          link
);
  logic       frag_vec;
  logic       first_msg;
  logic [1:0] dec_owed;
  logic       is_msg;
  logic       accept;

  assign link.d2h_ready = 1'b1;
  assign accept = link.d2h_valid;
  assign is_msg = link.d2h_data[31:28] == pkt_seq_pkg::PKT_MSG;
  assign link.h2d_valid = (dec_owed != 2'h0);
  assign link.h2d_data  = {pkt_seq_pkg::PKT_AFM, 27'h0, 1'b1};

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PKT_DATA  <= '0;
      O_PKT_VALID <= 1'b0;
    end else begin
      O_PKT_VALID <= accept;
      O_PKT_DATA  <= link.d2h_data;
    end
  end

  // One fragment message at a time; first message word decides
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      frag_vec       <= 1'b0;
      first_msg      <= 1'b0;
      dec_owed       <= 2'h0;
      O_FRAG_PENDING <= 8'h00;
    end else begin
      if (link.h2d_valid && link.h2d_ready) begin
        dec_owed <= dec_owed - 2'h1;
      end
      if (accept && link.d2h_data[31:28] == pkt_seq_pkg::PKT_VECTOR) begin
        frag_vec  <= pkt_seq_pkg::is_frag_type(link.d2h_data[2:0]);
        first_msg <= 1'b1;
      end else if (accept && is_msg && first_msg && frag_vec) begin
        first_msg <= 1'b0;
        if (!link.d2h_data[pkt_seq_pkg::PKT_CONT_BIT]) begin
          if (O_FRAG_PENDING != 8'h00) begin
            dec_owed       <= 2'h2;
            O_FRAG_PENDING <= O_FRAG_PENDING - 8'h01;
          end else begin
            dec_owed <= 2'h1;
          end
        end else if (O_FRAG_PENDING != 8'h00) begin
          dec_owed <= 2'h1;
        end else begin
          O_FRAG_PENDING <= O_FRAG_PENDING + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/pkt_seq_props.sv ====
// Link checker for the sequencer and host pair
`timescale 1ns/1ps
`default_nettype none
module pkt_seq_props (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // Device to host
  input  wire logic [31:0] d2h_data,
  input  wire logic        d2h_valid,
  input  wire logic        d2h_ready,
  // Host to device
  input  wire logic [31:0] h2d_data,
  input  wire logic        h2d_valid,
  input  wire logic        h2d_ready
);
  wire logic [3:0] t = d2h_data[31:28];
  wire logic [4:0] p = d2h_data[25:21];
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  property p_d2h_hold;
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
  endproperty
  a_d2h_hold: assert property (p_d2h_hold)
    else $error("packet dropped or changed before taken");
  property p_h2d_hold;
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
  endproperty
  a_h2d_hold: assert property (p_h2d_hold)
    else $error("host write changed before taken");
  property p_answer;
    h2d_valid && h2d_ready |-> ##1 d2h_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("host write got no answer packet");
  property p_eof;
    d2h_valid && t == pkt_seq_pkg::PKT_STATUS |-> d2h_data[0];
  endproperty
  a_eof: assert property (p_eof)
    else $error("status packet without end of frame bit");
  property p_no_biw0;
    d2h_valid && t == pkt_seq_pkg::PKT_BIW |-> p != 5'h00;
  endproperty
  a_no_biw0: assert property (p_no_biw0)
    else $error("info word at position zero forwarded");
  property p_host_afm;
    h2d_valid |-> h2d_data[31:28] == pkt_seq_pkg::PKT_AFM && h2d_data[0];
  endproperty
  a_host_afm: assert property (p_host_afm)
    else $error("host wrote other than a decrement");
  // Message words always lie after their vector
  property p_vec_range;
    d2h_valid && t == pkt_seq_pkg::PKT_VECTOR |->
      p < d2h_data[20:16] && d2h_data[20:16] <= d2h_data[15:11];
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("vector range malformed");
  property p_addr_pos;
    d2h_valid && t == pkt_seq_pkg::PKT_ADDR |-> p != 5'h00;
  endproperty
  a_addr_pos: assert property (p_addr_pos)
    else $error("address packet points at info word");
endmodule
`default_nettype wire

// ==== tb/tb_paging_message_packet_sequencer.sv ====
// Testbench for the sequencer, host end and packet FIFO
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_paging_message_packet_sequencer;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        vld = 1'b0, fe = 1'b0, en = 1'b0, faf = 1'b0, tmp = 1'b0;
  logic [2:0]  kind = 3'h7;
  logic [1:0]  ph = 2'h0, rate = 2'h1;
  logic [4:0]  pos = 5'h00;
  logic [20:0] dat = 21'h000000;
  logic        wrdy, allf, pv;
  logic [7:0]  afc, fp;
  logic [31:0] pd, g;
  logic [31:0] q[$];
  int          num_errors = 0, n_tests = 0, cnt = 0;

  always #12.5 clk = ~clk;

  pkt_seq_if i_pkt_seq_if ();
  pkt_seq_device i_pkt_seq_device (.I_CLK(clk), .I_RST_B(rst_b),
    .I_WORD_VALID(vld), .O_WORD_READY(wrdy), .I_WORD_KIND(kind),
    .I_PHASE(ph), .I_WORD_POSITION(pos), .I_WORD_DATA(dat),
    .I_FRAME_END(fe), .I_RATE(rate), .I_BIW_FWD_EN(en),
    .I_FORCED_ALL_FRAME_BIT(faf), .I_TEMP_ADDR_PENDING(tmp),
    .O_ALL_FRAME(allf), .O_AF_COUNT(afc), .link(i_pkt_seq_if));
  pkt_seq_host i_pkt_seq_host (.I_CLK(clk), .I_RST_B(rst_b),
    .O_PKT_DATA(pd), .O_PKT_VALID(pv), .O_FRAG_PENDING(fp),
    .link(i_pkt_seq_if));
  pkt_seq_props i_pkt_seq_props (.I_CLK(clk), .I_RST_B(rst_b),
    .d2h_data(i_pkt_seq_if.d2h_data), .d2h_valid(i_pkt_seq_if.d2h_valid),
    .d2h_ready(i_pkt_seq_if.d2h_ready), .h2d_data(i_pkt_seq_if.h2d_data),
    .h2d_valid(i_pkt_seq_if.h2d_valid), .h2d_ready(i_pkt_seq_if.h2d_ready));

  // Empty answer packets carry nothing for the host
  always @(posedge clk) begin
    if (pv === 1'b1 && pd[31:28] !== pkt_seq_pkg::PKT_NONE) q.push_back(pd);
  end

  function automatic logic [20:0] vd(input logic [4:0] a, b,
                                     input logic [2:0] v);
    return {8'h00, b, a, v};
  endfunction

  // Request held until the edge that takes it
  task automatic wr(input logic [2:0] k, input logic [1:0] f,
                    input logic [4:0] w, input logic [20:0] d,
                    input logic e = 1'b0);
    int n;
    @(negedge clk);
    kind = k; ph = f; pos = w; dat = d; fe = e; vld = 1'b1;
    n = 0;
    while (wrdy !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask

  task automatic idle(input int c);
    @(negedge clk);
    vld = 1'b0;
    fe = 1'b0;
    repeat (c) @(negedge clk);
  endtask

  // Position 5'h1F means neither phase nor position is compared
  task automatic ex(input logic [3:0] t, input logic [1:0] f,
                    input logic [4:0] w);
    int n;
    n = 0;
    while (q.size() == 0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    g = 32'h00000000;
    if (q.size() > 0) g = q.pop_front();
    `CHK(g[31:28], t)
    if (w !== 5'h1F) `CHK(g[27:21], {f, w})
  endtask

  task automatic summarize();
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    wr(pkt_seq_pkg::WK_BIW, 2'h2, 5'h01, 21'h000000);
    idle(8);
    `CHK(q.size(), 0)
    en = 1'b1;
    wr(pkt_seq_pkg::WK_BIW, 2'h0, 5'h00, 21'h000000);
    wr(pkt_seq_pkg::WK_ADDR, 2'h0, 5'h03, 21'h000007);
    wr(pkt_seq_pkg::WK_ADDR, 2'h0, 5'h04, 21'h000008);
    wr(pkt_seq_pkg::WK_VECTOR, 2'h0, 5'h07, vd(5'h09, 5'h0B, 3'h3));
    wr(pkt_seq_pkg::WK_BIW, 2'h2, 5'h00, 21'h000000);
    wr(pkt_seq_pkg::WK_BIW, 2'h2, 5'h01, 21'h000000);
    wr(pkt_seq_pkg::WK_BIW, 2'h2, 5'h03, 21'h000000);
    wr(pkt_seq_pkg::WK_LADDR, 2'h2, 5'h05, 21'h00000A);
    wr(pkt_seq_pkg::WK_VECTOR, 2'h0, 5'h08, vd(5'h0C, 5'h0F, 3'h3));
    for (int k = 9; k < 16; k++) wr(pkt_seq_pkg::WK_MSG, 2'h0, k[4:0], 21'h0);
    wr(pkt_seq_pkg::WK_VECTOR, 2'h2, 5'h0A, vd(5'h0E, 5'h0F, 3'h3));
    wr(pkt_seq_pkg::WK_MSG, 2'h2, 5'h0B, 21'h000000);
    wr(pkt_seq_pkg::WK_MSG, 2'h2, 5'h0E, 21'h000000);
    wr(pkt_seq_pkg::WK_MSG, 2'h2, 5'h0F, 21'h000000);
    idle(20);
    ex(pkt_seq_pkg::PKT_ADDR, 2'h0, 5'h07);
    ex(pkt_seq_pkg::PKT_ADDR, 2'h0, 5'h08);
    ex(pkt_seq_pkg::PKT_VECTOR, 2'h0, 5'h07);
    `CHK({g[20:11], g[2:0]}, {5'h09, 5'h0B, 3'h3})
    ex(pkt_seq_pkg::PKT_BIW, 2'h2, 5'h1F);
    ex(pkt_seq_pkg::PKT_BIW, 2'h2, 5'h1F);
    ex(pkt_seq_pkg::PKT_LADDR, 2'h2, 5'h1F);
    ex(pkt_seq_pkg::PKT_VECTOR, 2'h0, 5'h08);
    `CHK(g[20:11], {5'h0C, 5'h0F})
    for (int k = 9; k < 16; k++) ex(pkt_seq_pkg::PKT_MSG, 2'h0, k[4:0]);
    ex(pkt_seq_pkg::PKT_VECTOR, 2'h2, 5'h0A);
    `CHK(g[20:11], {5'h0E, 5'h0F})
    ex(pkt_seq_pkg::PKT_MSG, 2'h2, 5'h0B);
    ex(pkt_seq_pkg::PKT_MSG, 2'h2, 5'h0E);
    ex(pkt_seq_pkg::PKT_MSG, 2'h2, 5'h0F);
    `CHK(afc, 8'h00)
    // Only phases carried at each rate reach the host
    for (int r = 0; r < 3; r++) begin
      for (int f = 0; f < 4; f++) begin
        rate = r[1:0];
        wr(pkt_seq_pkg::WK_ADDR, f[1:0], 5'h03, 21'h000007);
        idle(8);
        `CHK(q.size(), (r == 2 || f == 0 || (r == 1 && f == 2)) ? 1 : 0)
        q.delete();
      end
    end
    rate = 2'h1;
    // Three fragments, the last with its continued flag clear
    for (int i = 0; i < 3; i++) begin
      wr(pkt_seq_pkg::WK_ADDR, 2'h0, 5'h03, 21'h000007);
      wr(pkt_seq_pkg::WK_VECTOR, 2'h0, 5'h07, vd(5'h09, 5'h09, 3'h5));
      wr(pkt_seq_pkg::WK_MSG, 2'h0, 5'h09, {(i < 2), 20'h00000}, 1'b1);
      idle(40);
      ex(pkt_seq_pkg::PKT_ADDR, 2'h0, 5'h07);
      ex(pkt_seq_pkg::PKT_VECTOR, 2'h0, 5'h07);
      ex(pkt_seq_pkg::PKT_MSG, 2'h0, 5'h09);
      `CHK(g[20], (i < 2))
      ex(pkt_seq_pkg::PKT_STATUS, 2'h0, 5'h1F);
      `CHK(g[0], 1'b1)
      `CHK(afc, (i < 2) ? 8'h01 : 8'h00)
      `CHK(allf, (i < 2))
    end
    `CHK(fp, 8'h00)
    // Zero count still held in all-frame by either level
    for (int j = 0; j < 4; j++) begin
      {faf, tmp} = j[1:0];
      idle(1);
      `CHK(allf, (j != 0))
    end
    {faf, tmp} = 2'h0;
    for (int v = 0; v < 8; v++) begin
      wr(pkt_seq_pkg::WK_VECTOR, 2'h0, 5'h07, vd(5'h09, 5'h09, v[2:0]));
      idle(6);
      if (v == 0 || v == 5 || v == 6) cnt++;
      `CHK(afc, cnt[7:0])
    end
    // Back-to-back words pass the packet queue in order
    q.delete();
    for (int k = 1; k < 5; k++) begin
      wr(pkt_seq_pkg::WK_ADDR, 2'h0, 5'h03, {16'h0000, k[4:0]});
    end
    idle(8);
    for (int k = 1; k < 5; k++) ex(pkt_seq_pkg::PKT_ADDR, 2'h0, k[4:0]);
    `CHK(q.size(), 0)
    `CHK(wrdy, 1'b1)
    `CHK(fp, 8'h00)
    summarize();
  end
endmodule
`default_nettype wire
